// *** src/fprp_prom_prog.sv ***
// Notes on behaviour
// [RQ1] Memory is 32 words of 8 bits
// [RQ2] Intact link reads HIGH, opened reads LOW
// [RQ3] Select HIGH turns all data outputs off
// [RQ4] Open-collector and three-state variants, same logic
// [RQ5] Address word, 20 V on bit, select 15 V
// [RQ6] After pulse drop voltage, enable, sense, repeat
// [RQ7] After LOW seen, pulse 100 us more
// [RQ8] Pulses start at 1 us, lengthen to 8 us
// [RQ9] Bit not open after 100 ms: defective
// [RQ10] Pulse budget 1.6 s, then 300/200 ms cycling
// [RQ11] Output at 20 V 100 ns before select
// [RQ12] Select disabled 100 ns before output rises
// [RQ13] Sense output 150 ns after select enabled
// [RQ14] Select low time 45 to 55 percent
// [RQ15] Middle selects at 13 V give test words
// [RQ16] Select line three at 13 V forces LOW
// [RQ17] Ninth test bit is never readable
// [RQ18] Tape: 25 rubouts, 32 words, 25 rubouts
// [RQ19] Record is B, eight P/N, then F
// [RQ20] Only P/N inside; rubouts cancel a word
// [RQ21] Text between records is ignored
// [RQ22] Transmitted tape uses even parity
// [RQ23] Program only LOW bits, verify each word
`default_nettype none
module fprp_prom_prog
	import fprp_pkg::*;
#(
	parameter int unsigned BIT_LIMIT_CYC = BIT_CYC,
	parameter int unsigned HEAT_LIM_CYC  = HEAT_CYC,
	parameter int unsigned COOL_LIM_CYC  = COOL_CYC,
	parameter int unsigned BURST_LIM_CYC = BURST_CYC
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         chr_valid,
	input  wire logic [7:0]   chr_data,
	input  wire logic         parity_en,
	input  wire logic         cmd_valid,
	output logic              cmd_ready,
	input  wire fprp_op_t     cmd_op,
	input  wire logic [4:0]   cmd_word,
	output logic              rsp_valid,
	output logic [7:0]        rsp_data,
	output fprp_result_t      rsp_result,
	output logic              tape_done,
	output logic              tape_err,
	input  wire logic [7:0]   data_out_bits,
	output fprp_pins_t        pins
);
	typedef enum {S_IDLE, S_RD, S_PICK, S_COOL, S_PRE, S_HV, S_PULSE, S_REC, S_VER} fprp_st_t;
	typedef enum {RK_CMD, RK_PRE, RK_POST} fprp_rk_t;

	fprp_img_wr_t wr;
	logic [7:0]   img [WORDS];
	logic [7:0]   d_meta, d_sync;

	fprp_st_t     st, next_st;
	fprp_rk_t     rk, next_rk;
	fprp_op_t     op, next_op;
	fprp_pins_t   next_pins;
	logic [31:0]  cnt, next_cnt;
	logic [31:0]  bit_time, next_bit_time;
	logic [31:0]  heat, next_heat;
	logic [31:0]  burst, next_burst;
	logic [15:0]  xtra, next_xtra;
	logic [8:0]   pulse_len, next_pulse_len;
	logic         opened, next_opened;
	logic         throttled, next_throttled;
	logic [4:0]   widx, next_widx;
	logic [2:0]   bidx, next_bidx;
	logic [7:0]   cur, next_cur;
	logic         next_rsp_valid;
	logic [7:0]   next_rsp_data;
	fprp_result_t next_rsp_result;
	logic         sample, bit_low, need_cool, bit_ok;
	logic [31:0]  hv_run, next_hv_run, lo_run, next_lo_run;
	logic         in_train, next_in_train;

	fprp_tape_rx u_tape (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.chr_valid (chr_valid),
		.chr_data  (chr_data),
		.parity_en (parity_en),
		.wr        (wr),
		.tape_done (tape_done),
		.tape_err  (tape_err)
	);

	// Powered, address on the lines, select and output high voltages as given, no 13 V selects
	function automatic fprp_pins_t mk_pins(logic [4:0] a, logic sn, logic hv, logic [7:0] ob);
		fprp_pins_t p;
		p          = '0;
		p.vcc_on   = 1'b1;
		p.word_sel = a;
		p.sel_n    = sn;
		p.sel_hv   = hv;
		p.out_hv   = ob;
		return p;
	endfunction

	function automatic fprp_pins_t rd_pins(logic [4:0] a, fprp_op_t o);
		fprp_pins_t p;
		p = mk_pins(a, 1'b0, 1'b0, 8'h00);
		case (o)
			OP_TEST0: begin
				p.a3_hv = 1'b1; // [RQ15]
				p.a2_hv = 1'b1;
				p.word_sel = 5'h00;
			end
			OP_TEST1: begin
				p.a3_hv = 1'b1; // [RQ15]
				p.a2_hv = 1'b1;
				p.word_sel = TEST_SEL_A1;
			end
			OP_LOWCHK: p.a3_hv = 1'b1; // [RQ16]
			default: p.a3_hv = 1'b0;
		endcase
		return p;
	endfunction

	assign cmd_ready = (st == S_IDLE);
	assign sample    = (st == S_RD || st == S_VER) && cnt == 32'(RD_WAIT_CYC); // [RQ13]
	assign bit_low   = !d_sync[bidx]; // [RQ2]
	assign need_cool = throttled ? (burst >= BURST_LIM_CYC) : (heat >= HEAT_LIM_CYC); // [RQ10]
	assign bit_ok    = st == S_VER && sample && (opened || bit_low) && 32'(xtra) >= XTRA_CYC;

	always_comb begin
		next_st = st; next_rk = rk; next_op = op; next_pins = pins;
		next_cnt = cnt + 32'h1; next_bit_time = bit_time; next_xtra = xtra;
		next_pulse_len = pulse_len; next_opened = opened; next_widx = widx;
		next_bidx = bidx; next_cur = cur; next_throttled = throttled;
		next_rsp_valid = 1'b0; next_rsp_data = rsp_data; next_rsp_result = rsp_result;
		next_heat  = pins.sel_hv ? heat + 32'h1 : heat;
		next_burst = (throttled && pins.vcc_on && st != S_IDLE) ? burst + 32'h1 : burst;
		next_hv_run = pins.sel_hv ? hv_run + 32'h1 : 32'h0;
		next_lo_run = pins.sel_hv ? 32'h0 : lo_run + 32'h1;
		// A non-zero high run with the select now low marks the end of a pulse
		next_in_train = (!pins.sel_hv && hv_run != 32'h0) ? 1'b1 : in_train;
		if (st inside {S_PRE, S_HV, S_PULSE, S_REC, S_VER}) next_bit_time = bit_time + 32'h1;
		if (opened && xtra != 16'hFFFF) next_xtra = xtra + 16'h1;
		case (st)
			S_IDLE: begin
				next_pins = mk_pins(5'h00, 1'b1, 1'b0, 8'h00); // [RQ3]
				if (cmd_valid) begin
					next_op  = cmd_op;
					next_cnt = 32'h0;
					if (cmd_op == OP_PROGRAM && !tape_done) begin
						next_rsp_valid  = 1'b1;
						next_rsp_result = RES_NOIMG;
					end else if (cmd_op == OP_PROGRAM) begin
						next_widx = 5'h00;
						next_rk   = RK_PRE;
						next_st   = S_RD;
						next_pins = rd_pins(5'h00, OP_READ);
					end else begin
						next_widx = cmd_word; // [RQ1]
						next_rk   = RK_CMD;
						next_st   = S_RD;
						next_pins = rd_pins(cmd_word, cmd_op);
					end
				end
			end
			S_RD: if (sample) begin
				next_cnt = 32'h0;
				case (rk)
					RK_CMD: begin
						next_rsp_valid = 1'b1; next_rsp_data = d_sync; // [RQ17]
						next_rsp_result = RES_OK; next_st = S_IDLE;
					end
					RK_PRE: begin
						next_cur = d_sync; next_bidx = 3'h7; next_st = S_PICK;
					end
					default: begin
						if (d_sync != img[widx] || widx == LAST_WORD) begin
							next_rsp_valid  = 1'b1; // [RQ23]
							next_rsp_data   = d_sync;
							next_rsp_result = (d_sync != img[widx]) ? RES_MISMATCH : RES_OK;
							next_st         = S_IDLE;
						end else begin
							next_widx = widx + 5'h01;
							next_rk   = RK_PRE;
							next_pins = rd_pins(widx + 5'h01, OP_READ);
						end
					end
				endcase
			end
			S_PICK: begin
				next_cnt = 32'h0; next_in_train = 1'b0;
				next_pins = mk_pins(widx, 1'b1, 1'b0, 8'h00);
				if (!img[widx][bidx] && cur[bidx]) begin
					next_pulse_len = 9'(PULSE_MIN_CYC); // [RQ8]
					next_bit_time = 32'h0; next_xtra = 16'h0; next_opened = 1'b0;
					next_st = S_PRE; // [RQ23]
				end else if (bidx == 3'h0) begin
					next_rk = RK_POST; next_st = S_RD; next_pins = rd_pins(widx, OP_READ);
				end else begin
					next_bidx = bidx - 3'h1;
				end
			end
			S_PRE: begin
				// Cooling only starts between pulses, never cutting one short
				if (cnt == 32'h0 && need_cool) begin
					next_cnt = 32'h0; next_st = S_COOL; next_pins = '0; // [RQ10]
				end else if (cnt == 32'(D3_CYC) - 32'h1) begin
					next_cnt = 32'h0; next_st = S_HV;
					next_pins = mk_pins(widx, 1'b1, 1'b0, 8'(8'h01 << bidx)); // [RQ12]
				end
			end
			S_COOL: begin
				next_bit_time = bit_time; next_in_train = 1'b0;
				if (cnt == COOL_LIM_CYC - 32'h1) begin
					next_throttled = 1'b1; next_burst = 32'h0; next_cnt = 32'h0;
					next_st = S_PRE; next_pins = mk_pins(widx, 1'b1, 1'b0, 8'h00);
				end
			end
			S_HV: if (cnt == 32'(D1_CYC) - 32'h1) begin
				next_cnt = 32'h0; next_st = S_PULSE;
				next_pins.sel_hv = 1'b1; // [RQ5] [RQ11]
			end
			S_PULSE: if (cnt == 32'(pulse_len) - 32'h1) begin
				next_cnt = 32'h0; next_st = S_REC;
				next_pins = mk_pins(widx, 1'b1, 1'b0, 8'h00); // [RQ6]
			end
			S_REC: if (cnt >= 32'(pulse_len) - 32'(LOW_TRIM_CYC) - 32'h1) begin
				next_cnt = 32'h0; next_st = S_VER; // [RQ14]
				next_pins.sel_n = 1'b0; // [RQ6]
			end
			S_VER: if (sample) begin
				next_cnt = 32'h0; next_pins.sel_n = 1'b1;
				if (opened || bit_low) begin
					next_opened = 1'b1; // [RQ7]
					if (bit_ok) begin
						next_cur[bidx] = 1'b0; next_st = S_PICK;
						if (bidx == 3'h0) begin
							next_rk = RK_POST; next_st = S_RD; next_pins = rd_pins(widx, OP_READ);
						end else begin
							next_bidx = bidx - 3'h1;
						end
					end else begin
						next_st = S_PRE;
					end
				end else if (bit_time >= BIT_LIMIT_CYC) begin
					next_rsp_valid = 1'b1; next_rsp_result = RES_DEFECT; // [RQ9]
					next_rsp_data = d_sync; next_st = S_IDLE;
				end else begin
					// Small steps keep the select duty inside its window
					next_pulse_len = (32'(pulse_len) + PULSE_STEP_CYC > PULSE_MAX_CYC) ?
						9'(PULSE_MAX_CYC) : pulse_len + 9'(PULSE_STEP_CYC); // [RQ8]
					next_st = S_PRE; // [RQ6]
				end
			end
			default: next_st = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			d_meta <= 8'hFF;
			d_sync <= 8'hFF;
		end else begin
			d_meta <= data_out_bits;
			d_sync <= d_meta;
		end
	end

	always_ff @(posedge clk) begin
		if (wr.en) img[wr.addr] <= wr.data;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= S_IDLE; rk <= RK_CMD; op <= OP_READ;
			pins <= '{vcc_on: 1'b1, sel_n: 1'b1, default: '0};
			cnt <= '0; bit_time <= '0; heat <= '0; burst <= '0; xtra <= '0;
			pulse_len <= 9'(PULSE_MIN_CYC); opened <= 1'b0; throttled <= 1'b0;
			widx <= '0; bidx <= '0; cur <= 8'hFF;
			rsp_valid <= 1'b0; rsp_data <= 8'h00; rsp_result <= RES_OK;
			hv_run <= '0; lo_run <= '0; in_train <= 1'b0;
		end else begin
			st <= next_st; rk <= next_rk; op <= next_op; pins <= next_pins;
			cnt <= next_cnt; bit_time <= next_bit_time; heat <= next_heat;
			burst <= next_burst; xtra <= next_xtra; pulse_len <= next_pulse_len;
			opened <= next_opened; throttled <= next_throttled;
			widx <= next_widx; bidx <= next_bidx; cur <= next_cur;
			rsp_valid <= next_rsp_valid; rsp_data <= next_rsp_data;
			rsp_result <= next_rsp_result;
			hv_run <= next_hv_run; lo_run <= next_lo_run; in_train <= next_in_train;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_out_rise;
		$rose(|pins.out_hv);
	endsequence

	sequence s_sel_hold;
		(!pins.sel_hv)[*4];
	endsequence

	a_sel_after_out: assert property (s_out_rise |-> s_sel_hold) // [RQ11]
		else $error("select raised too soon after output voltage");
	a_out_after_dis: assert property (s_out_rise |-> $past(pins.sel_n, 4) && pins.sel_n) // [RQ12]
		else $error("output raised without select disabled long enough");
	a_verify_wait: assert property (sample |-> $past(pins.sel_n, 8) == 1'b0) // [RQ13]
		else $error("output sensed before verify delay");
	a_pulse_width: assert property ($fell(pins.sel_hv) |->
		hv_run == 32'($past(pulse_len)) && hv_run >= 32'd40 && hv_run <= 32'd320) // [RQ8]
		else $error("programming pulse width wrong");
	a_pulse_guard: assert property (pins.sel_hv |-> (|pins.out_hv) && pins.vcc_on && pins.sel_n) // [RQ5]
		else $error("select pulse without output voltage");
	a_single_bit: assert property ($onehot0(pins.out_hv)) // [RQ5]
		else $error("more than one output at high voltage");
	a_cool_quiet: assert property ($fell(pins.vcc_on) |->
		(!pins.vcc_on && !pins.sel_hv && pins.out_hv == 8'h00)[*8]) // [RQ10]
		else $error("drive present while power removed");
	a_duty_window: assert property ($rose(pins.sel_hv) && in_train |->
		lo_run * 32'd20 >= (lo_run + 32'(pulse_len)) * 32'd9 &&
		lo_run * 32'd20 <= (lo_run + 32'(pulse_len)) * 32'd11) // [RQ14]
		else $error("select duty cycle outside window");
	a_bit_defect: assert property (st == S_VER && sample && !opened && !bit_low &&
		bit_time >= BIT_LIMIT_CYC |=> rsp_valid && rsp_result == RES_DEFECT) // [RQ9]
		else $error("defective bit not reported");
	a_xtra_time: assert property ($fell(opened) |-> 32'($past(xtra)) >= XTRA_CYC) // [RQ7]
		else $error("bit finished before extra pulses");
	a_skip_high: assert property (s_out_rise |-> !img[widx][bidx]) // [RQ23]
		else $error("pulsing a bit meant to stay high");
endmodule
`default_nettype wire

// *** src/fprp_pkg.sv ***
`default_nettype none
package fprp_pkg;
	localparam int unsigned CLK_MHZ = 40;

	// Times in their own units, as specified
	localparam int unsigned T_D1_NS         = 100;
	localparam int unsigned T_D3_NS         = 100;
	localparam int unsigned T_DV_NS         = 150;
	localparam int unsigned T_PULSE_MIN_NS  = 1000;
	localparam int unsigned T_PULSE_MAX_NS  = 8000;
	localparam int unsigned T_PULSE_STEP_NS = 125;
	localparam int unsigned T_XTRA_US       = 100;
	localparam int unsigned T_BIT_MS        = 100;
	localparam int unsigned T_HEAT_MS       = 1600;
	localparam int unsigned T_COOL_MS       = 300;
	localparam int unsigned T_BURST_MS      = 200;

	// Least times round up, longest times round down
	localparam int unsigned D1_CYC         = (T_D1_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned D3_CYC         = (T_D3_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DV_CYC         = (T_DV_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PULSE_MIN_CYC  = (T_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PULSE_MAX_CYC  = T_PULSE_MAX_NS * CLK_MHZ / 1000;
	localparam int unsigned PULSE_STEP_CYC = (T_PULSE_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned XTRA_CYC       = T_XTRA_US * CLK_MHZ;
	localparam int unsigned BIT_CYC        = T_BIT_MS * CLK_MHZ * 1000;
	localparam int unsigned HEAT_CYC       = T_HEAT_MS * CLK_MHZ * 1000;
	localparam int unsigned COOL_CYC       = T_COOL_MS * CLK_MHZ * 1000;
	localparam int unsigned BURST_CYC      = T_BURST_MS * CLK_MHZ * 1000;

	// Data pins pass two sync stages before a sample is taken
	localparam int unsigned SYNC_LAT       = 2;
	localparam int unsigned RD_WAIT_CYC    = DV_CYC + SYNC_LAT;
	localparam int unsigned LOW_TRIM_CYC   = D1_CYC + D3_CYC + RD_WAIT_CYC + 1;

	localparam int unsigned WORDS          = 32;
	localparam int unsigned WBITS          = 8;
	localparam int unsigned ABITS          = 5;
	localparam logic [4:0]  LAST_WORD      = 5'h1F;
	localparam logic [4:0]  TEST_SEL_A1    = 5'h02;

	localparam int unsigned LEADER_MIN     = 25;
	localparam int unsigned TRAILER_MIN    = 25;
	localparam logic [6:0]  CH_RUBOUT      = 7'h7F;
	localparam logic [6:0]  CH_START       = 7'h42;
	localparam logic [6:0]  CH_HIGH        = 7'h50;
	localparam logic [6:0]  CH_LOW         = 7'h4E;
	localparam logic [6:0]  CH_FINISH      = 7'h46;

	typedef enum logic [2:0] {
		OP_READ,
		OP_PROGRAM,
		OP_TEST0,
		OP_TEST1,
		OP_LOWCHK
	} fprp_op_t;

	typedef enum logic [1:0] {
		RES_OK,
		RES_DEFECT,
		RES_MISMATCH,
		RES_NOIMG
	} fprp_result_t;

	// Digital controls for the level drivers in front of the memory
	typedef struct packed {
		logic       vcc_on;
		logic [4:0] word_sel;
		logic       sel_n;
		logic       sel_hv;
		logic [7:0] out_hv;
		logic       a3_hv;
		logic       a2_hv;
	} fprp_pins_t;

	typedef struct packed {
		logic       en;
		logic [4:0] addr;
		logic [7:0] data;
	} fprp_img_wr_t;
endpackage
`default_nettype wire

// *** src/fprp_tape_rx.sv ***
`default_nettype none
module fprp_tape_rx
	import fprp_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         chr_valid,
	input  wire logic [7:0]   chr_data,
	input  wire logic         parity_en,
	output fprp_img_wr_t      wr,
	output logic              tape_done,
	output logic              tape_err
);
	typedef enum {P_LEAD, P_GAP, P_BITS, P_FIN, P_CANCEL, P_TRAIL, P_DONE, P_ERR} fprp_pst_t;

	fprp_pst_t    st, next_st;
	logic [5:0]   rub, next_rub;
	logic [3:0]   nbits, next_nbits;
	logic [7:0]   shreg, next_shreg;
	logic [5:0]   widx, next_widx;
	fprp_img_wr_t next_wr;
	logic [6:0]   ch;

	assign ch = chr_data[6:0];

	always_comb begin
		next_st    = st;
		next_rub   = rub;
		next_nbits = nbits;
		next_shreg = shreg;
		next_widx  = widx;
		next_wr    = '{en: 1'b0, addr: widx[4:0], data: shreg};
		if (chr_valid && st != P_DONE && st != P_ERR) begin
			if (parity_en && ^chr_data) begin
				next_st = P_ERR; // [RQ22]
			end else begin
				case (st)
					P_LEAD: begin
						if (ch == CH_RUBOUT) begin
							next_rub = (rub == 6'h3F) ? rub : rub + 6'h01;
						end else if (32'(rub) < LEADER_MIN) begin
							next_st = P_ERR; // [RQ18]
						end else begin
							next_st = (ch == CH_START) ? P_BITS : P_GAP;
							next_nbits = 4'h0;
						end
					end
					P_GAP, P_CANCEL: begin
						// Text between records, cancel rubouts included, is skipped
						if (ch == CH_START) begin
							next_st    = P_BITS; // [RQ21]
							next_nbits = 4'h0;
						end else begin
							next_st = P_GAP;
						end
					end
					P_BITS: begin
						if (ch == CH_HIGH || ch == CH_LOW) begin
							next_shreg = {shreg[6:0], ch == CH_HIGH}; // [RQ19]
							next_nbits = nbits + 4'h1;
							if (nbits == 4'h7) next_st = P_FIN;
						end else if (ch == CH_RUBOUT) begin
							next_st = P_CANCEL; // [RQ20]
						end else begin
							next_st = P_ERR; // [RQ20]
						end
					end
					P_FIN: begin
						if (ch == CH_FINISH) begin
							next_wr.en = 1'b1; // [RQ19]
							next_widx  = widx + 6'h01;
							next_rub   = 6'h00;
							next_st    = (widx[4:0] == LAST_WORD) ? P_TRAIL : P_GAP; // [RQ18]
						end else if (ch == CH_RUBOUT) begin
							next_st = P_CANCEL; // [RQ20]
						end else begin
							next_st = P_ERR;
						end
					end
					P_TRAIL: begin
						if (ch == CH_RUBOUT) begin
							next_rub = rub + 6'h01;
							if (32'(rub) + 1 >= TRAILER_MIN) next_st = P_DONE; // [RQ18]
						end else if (ch == CH_START) begin
							next_st = P_ERR;
						end else begin
							next_rub = 6'h00;
						end
					end
					default: next_st = P_ERR;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st    <= P_LEAD;
			rub   <= 6'h00;
			nbits <= 4'h0;
			shreg <= 8'h00;
			widx  <= 6'h00;
			wr    <= '0;
		end else begin
			st    <= next_st;
			rub   <= next_rub;
			nbits <= next_nbits;
			shreg <= next_shreg;
			widx  <= next_widx;
			wr    <= next_wr;
		end
	end

	assign tape_done = (st == P_DONE);
	assign tape_err  = (st == P_ERR);
endmodule
`default_nettype wire

// *** testbench/fprp_prom_dev.sv ***
`default_nettype none
module fprp_prom_dev
	import fprp_pkg::*;
#(
	parameter int unsigned OPEN_PULSES = 3,
	parameter logic [4:0]  STUCK_WORD  = 5'h05,
	parameter logic [7:0]  TEST_W0     = 8'hC3,
	parameter logic [7:0]  TEST_W1     = 8'h96
) (
	input  wire fprp_pins_t pins,
	output logic [7:0]      data_out_bits,
	output int unsigned     viol
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  fuse [WORDS];
	int unsigned hits [WORDS][WBITS];
	logic [7:0]  last;
	logic [7:0]  val;
	realtime     t_hv;
	realtime     t_sn;
	realtime     t_p;
	wire logic   any_hv = |pins.out_hv;

	initial begin
		foreach (fuse[i]) fuse[i] = 8'hFF;
		foreach (hits[i, j]) hits[i][j] = 0;
		last = 8'h00;
		viol = 0;
		t_hv = 0.0;
		t_sn = 0.0;
		t_p = 0.0;
	end

	// Links melt after a few pulses; bit 0 of one word never opens
	always @(posedge pins.sel_hv) begin
		if (!any_hv || $realtime - t_hv < 100.0) viol++;
		t_p = $realtime;
		for (int b = 0; b < 8; b++) begin
			if (pins.vcc_on && pins.out_hv[b] && !(pins.word_sel == STUCK_WORD && b == 0)) begin
				hits[pins.word_sel][b]++;
				if (hits[pins.word_sel][b] >= OPEN_PULSES) fuse[pins.word_sel][b] = 1'b0;
			end
		end
	end

	always @(negedge pins.sel_hv) begin
		if (t_p > 0.0 && ($realtime - t_p < 1000.0 || $realtime - t_p > 8000.0)) viol++;
	end

	always @(posedge pins.sel_n) t_sn = $realtime;

	always @(posedge any_hv) begin
		t_hv = $realtime;
		if (pins.sel_n !== 1'b1 || $realtime - t_sn < 100.0) viol++;
	end

	// Floating outputs show the inverse of the last driven word, so an early
	// sample cannot pass by luck
	always @(pins) begin
		if (!pins.vcc_on || pins.sel_n || pins.sel_hv) begin
			data_out_bits = ~last;
		end else begin
			if (pins.a3_hv && pins.a2_hv) val = pins.word_sel[1] ? TEST_W1 : TEST_W0;
			else if (pins.a3_hv) val = 8'h00;
			else val = fuse[pins.word_sel];
			data_out_bits = val;
			last = val;
		end
	end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`default_nettype none
module tb_top
	import fprp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned COOL = 50;
	localparam logic [7:0]  TW0  = 8'hC3;
	localparam logic [7:0]  TW1  = 8'h96;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         chr_valid = 1'b0;
	logic         parity_en = 1'b0;
	logic         cmd_valid = 1'b0;
	logic [7:0]   chr_data = 8'h00;
	fprp_op_t     cmd_op = OP_READ;
	logic [4:0]   cmd_word = 5'h00;
	logic         cmd_ready;
	logic         rsp_valid;
	logic         tape_done;
	logic         tape_err;
	logic [7:0]   rsp_data;
	logic [7:0]   data_out_bits;
	fprp_result_t rsp_result;
	fprp_pins_t   pins;
	int unsigned  viol;
	int unsigned  error_cnt = 0;
	int unsigned  num_checks = 0;
	int unsigned  off_cnt = 0;
	logic         cool_seen = 1'b0;
	logic [7:0]   img [32];

	always #12.5 clk = ~clk;

	fprp_prom_prog #(.BIT_LIMIT_CYC(2000), .HEAT_LIM_CYC(3000), .COOL_LIM_CYC(COOL),
		.BURST_LIM_CYC(1000)) dut (.clk(clk), .sys_rst(sys_rst), .chr_valid(chr_valid),
		.chr_data(chr_data), .parity_en(parity_en), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_word(cmd_word), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_result(rsp_result), .tape_done(tape_done),
		.tape_err(tape_err), .data_out_bits(data_out_bits), .pins(pins));

	fprp_prom_dev #(.TEST_W0(TW0), .TEST_W1(TW1)) dev (.pins(pins),
		.data_out_bits(data_out_bits), .viol(viol));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Each power-off stretch must last exactly the cool-off time
	always @(posedge clk) begin
		if (sys_rst) begin
			off_cnt = 0;
		end else if (!pins.vcc_on) begin
			off_cnt++;
		end else if (off_cnt != 0) begin
			check(8'(off_cnt), 8'(COOL));
			cool_seen = 1'b1;
			off_cnt = 0;
		end
	end

	task automatic do_reset();
		fprp_pins_t p;
		p = '0;
		p.vcc_on = 1'b1;
		p.sel_n = 1'b1;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (16) @(posedge clk);
		#1;
		check(8'(pins == p), 8'h01);
		check({5'h00, cmd_ready, tape_done, tape_err}, 8'h04);
		@(posedge clk);
		sys_rst <= 1'b0;
	endtask

	task automatic do_cmd(input fprp_op_t op, input logic [4:0] w, output int unsigned n);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_word <= w;
		// Ready is looked at mid-cycle, where it has settled for the next edge
		@(negedge clk);
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		#1;
		// A refused program answers at the accept edge itself
		while (rsp_valid !== 1'b1 && n < 60000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (rsp_valid !== 1'b1) check(8'h00, 8'h01);
	endtask

	task automatic rd(input fprp_op_t op, input logic [4:0] w, input logic [7:0] exp);
		int unsigned n;
		do_cmd(op, w, n);
		check(8'(n), 8'(RD_WAIT_CYC + 1));
		check(rsp_data, exp);
	endtask

	task automatic chr(input logic [6:0] c);
		@(posedge clk);
		chr_valid <= 1'b1;
		chr_data <= {parity_en & ^c, c};
	endtask

	task automatic tape(input int unsigned lead);
		repeat (lead) chr(CH_RUBOUT);
		for (int w = 0; w < 32; w++) begin
			chr(7'h0D);
			chr(7'h0A);
			if (w == 1) begin
				chr(CH_START);
				chr(CH_HIGH);
				chr(CH_LOW);
				repeat (3) chr(CH_RUBOUT);
			end
			chr(CH_START);
			for (int b = 7; b >= 0; b--) chr(img[w][b] ? CH_HIGH : CH_LOW);
			chr(CH_FINISH);
		end
		repeat (25) chr(CH_RUBOUT);
		@(posedge clk);
		chr_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic prog(input fprp_result_t exp, output int unsigned n);
		tape(25);
		check({7'h00, tape_done}, 8'h01);
		do_cmd(OP_PROGRAM, 5'h00, n);
		check(8'(rsp_result), 8'(exp));
	endtask

	task automatic t_fresh();
		int unsigned n;
		do_reset();
		rd(OP_READ, 5'h00, 8'hFF);
		rd(OP_READ, 5'h1F, 8'hFF);
		rd(OP_TEST0, 5'h00, TW0);
		rd(OP_TEST1, 5'h00, TW1);
		rd(OP_LOWCHK, 5'h00, 8'h00);
		tape(10);
		check({6'h00, tape_err, tape_done}, 8'h02);
		do_cmd(OP_PROGRAM, 5'h00, n);
		check(8'(rsp_result), 8'(RES_NOIMG));
		$display("test fresh and bad tape done");
	endtask

	task automatic t_program();
		int unsigned n;
		do_reset();
		parity_en <= 1'b1;
		foreach (img[i]) img[i] = 8'hFF;
		img[0] = 8'hFE;
		img[9] = 8'h7F;
		img[31] = 8'hDF;
		prog(RES_OK, n);
		check(8'(n >= 3 * XTRA_CYC), 8'h01);
		for (int w = 0; w < 32; w++) rd(OP_READ, 5'(w), img[w]);
		check(8'(viol), 8'h00);
		check({7'h00, cool_seen}, 8'h01);
		$display("test program done");
	endtask

	task automatic t_faults();
		int unsigned n;
		do_reset();
		parity_en <= 1'b0;
		img[5] = 8'hFE;
		prog(RES_DEFECT, n);
		check(8'(n >= 2000), 8'h01);
		rd(OP_READ, 5'h05, 8'hFF);
		do_reset();
		img[5] = 8'hFF;
		img[0] = 8'hFF;
		prog(RES_MISMATCH, n);
		check(rsp_data, 8'hFE);
		$display("test defect and mismatch done");
	endtask

	initial begin
		t_fresh();
		t_program();
		t_faults();
		wrap_up();
	end

	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule
`default_nettype wire
